// [verilog/dpwm_top.sv]
// dual pwm generator: registers, shared counter, two channels
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
module dpwm_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        size,
  output logic      [15:0] rdata,
  output logic             port_pin_ch0,
  output logic             port_pin_ch1
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [11:0] mask_of(input logic [1:0] res);
    case (res)
      dpwm_pkg::RES_8:  mask_of = 12'h0FF;
      dpwm_pkg::RES_10: mask_of = 12'h3FF;
      default:          mask_of = 12'hFFF;
    endcase
  endfunction

  // merge a byte or word write into a 12-bit buffer
  function automatic logic [11:0] merge(input logic [11:0] old,
                                        input logic [15:0] d,
                                        input logic        word);
    merge = word ? d[11:0] : {old[11:8], d[7:0]};
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  modulator_control_q;
  logic [11:0] width_buffer_ch0_q;
  logic [11:0] width_buffer_ch1_q;
  logic [15:0] rdata_d;

  wire logic sel_ctl = (addr == dpwm_pkg::ADDR_CONTROL);
  wire logic sel_b0  = (addr == dpwm_pkg::ADDR_BUF0_LO);
  wire logic sel_b1  = (addr == dpwm_pkg::ADDR_BUF1_LO);
  // high byte alone is not addressable; such writes are dropped
  wire logic wr_b0   = wr && sel_b0;
  wire logic wr_b1   = wr && sel_b1;
  wire logic word    = (size == dpwm_pkg::SIZE_WORD);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      modulator_control_q <= dpwm_pkg::CTL_RESET;
    else if (ce && wr && sel_ctl)
      modulator_control_q <= wdata[7:0];
  end

  // buffers carry no reset: software loads them before enabling
  always_ff @(posedge clk_sys)
  begin
    if (ce && wr_b0)
      width_buffer_ch0_q <= merge(width_buffer_ch0_q, wdata, word);
    if (ce && wr_b1)
      width_buffer_ch1_q <= merge(width_buffer_ch1_q, wdata, word);
  end

  always_comb
  begin
    rdata_d = 16'h0000;
    if (sel_ctl)
      rdata_d = {8'h00, modulator_control_q};
    else if (sel_b0)
      rdata_d = word ? {4'h0, width_buffer_ch0_q}
                     : {8'h00, width_buffer_ch0_q[7:0]};
    else if (sel_b1)
      rdata_d = word ? {4'h0, width_buffer_ch1_q}
                     : {8'h00, width_buffer_ch1_q[7:0]};
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (ce)
      rdata <= rd ? rdata_d : 16'h0000;
  end

  // ****************************************************************
  // shared control counter
  // ****************************************************************
  logic [0:0]  pre_q;
  logic [11:0] cnt_q;
  wire  logic [1:0]  res    = modulator_control_q[dpwm_pkg::BIT_RES_HI:
                                                  dpwm_pkg::BIT_RES_LO];
  wire  logic [11:0] rmask  = mask_of(res);
  wire  logic        step   = (pre_q == dpwm_pkg::PRESCALE_LAST);
  wire  logic [11:0] cnt_m  = cnt_q & rmask;
  wire  logic        ovf    = step && (cnt_m == rmask);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pre_q <= 1'b0;
    else if (ce)
      pre_q <= step ? 1'b0 : pre_q + 1'b1;
  end

  // wraps at the selected length; stale high bits are masked off
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 12'h000;
    else if (ce && step)
      cnt_q <= ovf ? 12'h000 : cnt_m + 12'h001;
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  dpwm_channel u_ch0 (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .ce         (ce),
    .step       (step),
    .ovf        (ovf),
    .cnt_masked (cnt_m),
    .buffer     (width_buffer_ch0_q),
    .res_mask   (rmask),
    .enable     (modulator_control_q[dpwm_pkg::BIT_EN0]),
    .level_sel  (modulator_control_q[dpwm_pkg::BIT_LPS0]),
    .pin        (port_pin_ch0)
  );

  dpwm_channel u_ch1 (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .ce         (ce),
    .step       (step),
    .ovf        (ovf),
    .cnt_masked (cnt_m),
    .buffer     (width_buffer_ch1_q),
    .res_mask   (rmask),
    .enable     (modulator_control_q[dpwm_pkg::BIT_EN1]),
    .level_sel  (modulator_control_q[dpwm_pkg::BIT_LPS1]),
    .pin        (port_pin_ch1)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ctl_reset;
    @(posedge clk_sys) $rose(nrst) |-> modulator_control_q == 8'h00;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("ctl not zero");

  property p_step_two;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && step) ##1 ce |-> !step;
  endproperty
  a_step_two: assert property (p_step_two)
    else $error("step too often");

  property p_cnt_adv;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && step && !ovf) |=> cnt_q == $past(cnt_m) + 12'h001;
  endproperty
  a_cnt_adv: assert property (p_cnt_adv)
    else $error("count wrong");

  property p_cnt_wrap;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && ovf) |=> cnt_q == 12'h000;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap)
    else $error("no wrap");

  property p_load;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && ovf) |=> u_ch0.compare_q == $past(width_buffer_ch0_q);
  endproperty
  a_load: assert property (p_load)
    else $error("compare not loaded");

  property p_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !ovf |=> $stable(u_ch1.compare_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("compare moved");

  property p_rise;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && ovf) ##1 ce |=> u_ch0.active_q;
  endproperty
  a_rise: assert property (p_rise)
    else $error("no active");

  property p_fall;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && step && !ovf && u_ch1.match) |=> !u_ch1.active_q;
  endproperty
  a_fall: assert property (p_fall)
    else $error("no inactive");

  property p_off;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && !modulator_control_q[dpwm_pkg::BIT_EN0]) |=> !port_pin_ch0;
  endproperty
  a_off: assert property (p_off)
    else $error("pin on while off");

  property p_off1;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && !modulator_control_q[dpwm_pkg::BIT_EN1]) |=> !port_pin_ch1;
  endproperty
  a_off1: assert property (p_off1)
    else $error("pin one on while off");

  property p_fall0;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && step && !ovf && u_ch0.match) |=> !u_ch0.active_q;
  endproperty
  a_fall0: assert property (p_fall0)
    else $error("no inactive on channel zero");

  property p_load1;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && ovf) |=> u_ch1.compare_q == $past(width_buffer_ch1_q);
  endproperty
  a_load1: assert property (p_load1)
    else $error("compare one not loaded");

  property p_hold0;
    @(posedge clk_sys) disable iff (!nrst)
      !ovf |=> $stable(u_ch0.compare_q);
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("compare zero moved");

  property p_ctl_write;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && wr && sel_ctl) |=> modulator_control_q == $past(wdata[7:0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("ctl not written");

  property p_ctl_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !(ce && wr && sel_ctl) |=> $stable(modulator_control_q);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("ctl changed without write");

  // buffer checks only follow a write: until then the buffers hold unknowns
  property p_buf_word;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && wr_b0 && word) |=> width_buffer_ch0_q == $past(wdata[11:0]);
  endproperty
  a_buf_word: assert property (p_buf_word)
    else $error("word write lost");

  property p_buf_byte;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && wr_b1 && !word) |=> width_buffer_ch1_q[7:0] == $past(wdata[7:0]);
  endproperty
  a_buf_byte: assert property (p_buf_byte)
    else $error("byte write lost");

  property p_hi_drop;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && wr && addr == dpwm_pkg::ADDR_BUF0_HI) |=>
        width_buffer_ch0_q == $past(width_buffer_ch0_q);
  endproperty
  a_hi_drop: assert property (p_hi_drop)
    else $error("high byte write taken");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && !rd) |=> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared");

  property p_rd_ctl;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && rd && sel_ctl) |=> rdata == {8'h00, $past(modulator_control_q)};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("ctl read wrong");

  property p_rd_narrow;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && rd && !word) |=> rdata[15:8] == 8'h00;
  endproperty
  a_rd_narrow: assert property (p_rd_narrow)
    else $error("byte read too wide");

  property p_pre_alt;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && nrst) |=> pre_q != $past(pre_q);
  endproperty
  a_pre_alt: assert property (p_pre_alt)
    else $error("prescaler stuck");

  property p_freeze;
    @(posedge clk_sys) disable iff (!nrst)
      !ce |=> $stable(cnt_q) && $stable(pre_q) &&
              $stable(modulator_control_q) && $stable(rdata);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");
endmodule
`default_nettype wire

// [verilog/dpwm_pkg.sv]
// package: register map, field layout and timing for the dual pwm block
`default_nettype none
package dpwm_pkg;
  // register offsets, byte addresses on the plain register port
  localparam logic [3:0] ADDR_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_BUF0_LO  = 4'h4;
  localparam logic [3:0] ADDR_BUF0_HI  = 4'h5;
  localparam logic [3:0] ADDR_BUF1_LO  = 4'h8;
  localparam logic [3:0] ADDR_BUF1_HI  = 4'h9;
  localparam int         ADDR_W        = 4;
  localparam int         DATA_W        = 16;
  localparam int         WIDTH_W       = 12;
  // control register layout
  localparam int         CTL_W         = 8;
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam int         BIT_EN0       = 0;
  localparam int         BIT_EN1       = 1;
  localparam int         BIT_LPS0      = 2;
  localparam int         BIT_RES_LO    = 4;
  localparam int         BIT_RES_HI    = 5;
  localparam int         BIT_LPS1      = 3;
  // resolution codes in the control register
  localparam logic [1:0] RES_8         = 2'h0;
  localparam logic [1:0] RES_10        = 2'h1;
  localparam logic [1:0] RES_12        = 2'h2;
  // counter advances once every this many system clocks
  localparam int         STEP_CLKS     = 2;
  localparam logic [0:0] PRESCALE_LAST = 1'(STEP_CLKS - 1);
  // access size on the bus
  localparam logic       SIZE_BYTE     = 1'b0;
  localparam logic       SIZE_WORD     = 1'b1;
endpackage
`default_nettype wire

// [verilog/dpwm_channel.sv]
// one pwm channel: hidden compare register and output flop
`timescale 1ns/100ps
`default_nettype none
module dpwm_channel (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        step,
  input  wire logic        ovf,
  input  wire logic [11:0] cnt_masked,
  input  wire logic [11:0] buffer,
  input  wire logic [11:0] res_mask,
  input  wire logic        enable,
  input  wire logic        level_sel,
  output logic             pin
);
  logic [11:0] compare_q;
  logic        active_q;
  wire  logic  match = ((compare_q & res_mask) == cnt_masked);

  // compare register has no software path at all
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      compare_q <= 12'h000;
    else if (ce && ovf)
      compare_q <= buffer;
  end

  // overflow wins over match so a zero width still gives one step high
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      active_q <= 1'b0;
    else if (ce && ovf)
      active_q <= 1'b1;
    else if (ce && step && match)
      active_q <= 1'b0;
  end

  // level select picks the polarity of the active phase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pin <= 1'b0;
    else if (ce)
      pin <= enable ? (active_q ^ level_sel) : 1'b0;
  end
endmodule
`default_nettype wire

// [bench/dpwm_load_model.sv]
// load model: measures high time and period of one pwm pin
`timescale 1ns/100ps
`default_nettype none
module dpwm_load_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic pin,
  output int        high_len,
  output int        period_len
);
  int   hi_cnt;
  int   per_cnt;
  logic pin_q;
  // filter sees whole cycles only; period latches at each rising edge of the pin, high time at each falling edge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_q      <= 1'b0;
      hi_cnt     <= 0;
      per_cnt    <= 0;
      high_len   <= 0;
      period_len <= 0;
    end
    else
    begin
      pin_q <= pin;
      if (pin && !pin_q)
      begin
        period_len <= per_cnt;
        per_cnt    <= 1;
      end
      else
        per_cnt <= per_cnt + 1;
      if (pin)
        hi_cnt <= pin_q ? hi_cnt + 1 : 1;
      else if (pin_q)
        high_len <= hi_cnt;
    end
  end
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the dual pwm block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        size    = 1'b0;
  logic        ce      = 1'b1;
  logic [15:0] rdata;
  logic        pin0;
  logic        pin1;
  int          hi0, per0, hi1, per1;
  int          fails       = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  always #5 clk_sys = ~clk_sys;
  dpwm_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .size(size), .rdata(rdata),
    .port_pin_ch0(pin0), .port_pin_ch1(pin1));
  dpwm_load_model u_load0 (.clk_sys(clk_sys), .nrst(nrst), .pin(pin0),
    .high_len(hi0), .period_len(per0));
  dpwm_load_model u_load1 (.clk_sys(clk_sys), .nrst(nrst), .pin(pin1),
    .high_len(hi1), .period_len(per1));
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic s,
                        input logic [15:0] d);
    @(posedge clk_sys);
    addr  <= a;
    size  <= s;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask
  task automatic rd_check(input logic [3:0] a, input logic s,
                          input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    size <= s;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 check({16'h0000, rdata}, {16'h0000, exp});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_check(dpwm_pkg::ADDR_CONTROL, dpwm_pkg::SIZE_BYTE, 16'h0000);
    // read data stand for one cycle only
    @(posedge clk_sys);
    #1 check({16'h0000, rdata}, 32'h00000000);
    rd_check(4'h2, dpwm_pkg::SIZE_WORD, 16'h0000);
  endtask
  task automatic t_regs();
    // high part only by word access, low byte also by byte access
    wr_reg(dpwm_pkg::ADDR_BUF0_LO, dpwm_pkg::SIZE_WORD, 16'h0ABC);
    wr_reg(dpwm_pkg::ADDR_BUF1_LO, dpwm_pkg::SIZE_WORD, 16'h0345);
    rd_check(dpwm_pkg::ADDR_BUF0_LO, dpwm_pkg::SIZE_WORD, 16'h0ABC);
    rd_check(dpwm_pkg::ADDR_BUF0_LO, dpwm_pkg::SIZE_BYTE, 16'h00BC);
    // a write aimed at the high byte alone must be dropped
    wr_reg(dpwm_pkg::ADDR_BUF0_HI, dpwm_pkg::SIZE_BYTE, 16'h00FF);
    rd_check(dpwm_pkg::ADDR_BUF0_LO, dpwm_pkg::SIZE_WORD, 16'h0ABC);
    wr_reg(dpwm_pkg::ADDR_BUF1_LO, dpwm_pkg::SIZE_BYTE, 16'h0012);
    rd_check(dpwm_pkg::ADDR_BUF1_LO, dpwm_pkg::SIZE_WORD, 16'h0312);
  endtask
  // load both widths, set control, let three periods run, then measure
  task automatic t_pwm(input logic [7:0] ctl, input logic [11:0] w0,
                       input logic [11:0] w1, input int period);
    wr_reg(dpwm_pkg::ADDR_BUF0_LO, dpwm_pkg::SIZE_WORD, {4'h0, w0});
    wr_reg(dpwm_pkg::ADDR_BUF1_LO, dpwm_pkg::SIZE_WORD, {4'h0, w1});
    wr_reg(dpwm_pkg::ADDR_CONTROL, dpwm_pkg::SIZE_BYTE, {8'h00, ctl});
    rd_check(dpwm_pkg::ADDR_CONTROL, dpwm_pkg::SIZE_BYTE,
             {8'h00, ctl});
    repeat (3 * period) @(posedge clk_sys);
    check(per0, period);
    check(per1, period);
    check(hi0, 2 * (w0 + 1));
    if (ctl[dpwm_pkg::BIT_LPS1])
      check(hi1, period - 2 * (w1 + 1));
    else
      check(hi1, 2 * (w1 + 1));
  endtask
  task automatic t_disable();
    wr_reg(dpwm_pkg::ADDR_CONTROL, dpwm_pkg::SIZE_BYTE, 16'h0000);
    repeat (600) @(posedge clk_sys);
    check({pin1, pin0}, 2'b00);
  endtask
  // enable low: pins hold and a write in the meantime is ignored
  task automatic t_freeze();
    logic [1:0] snap;
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    #1 snap = {pin1, pin0};
    wr_reg(dpwm_pkg::ADDR_CONTROL, dpwm_pkg::SIZE_BYTE, 16'h0000);
    repeat (20) @(posedge clk_sys);
    #1 check({pin1, pin0}, snap);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd_check(dpwm_pkg::ADDR_CONTROL, dpwm_pkg::SIZE_BYTE, 16'h0023);
  endtask
  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ceiling sized for about 34.5k cycles of planned traffic
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_pwm(8'h0B, 12'h010, 12'h07F, 512);
    t_pwm(8'h0B, 12'h040, 12'h020, 512);
    t_pwm(8'h13, 12'h200, 12'h001, 2048);
    t_pwm(8'h23, 12'h800, 12'h000, 8192);
    t_freeze();
    t_disable();
    conclude();
  end
endmodule
`default_nettype wire
